// *** core/boot_mode_strap_and_chip_id.sv ***
// Boot mode strap capture, PLL lock wait and family identification
// Operation
// - Family identification at C2H is read-only; writes change nothing.
// - Upper nibble holds the family code that software branches on.
// - Fetch strobe pin is sampled only at the reset release edge.
// - Strobe sampled low selects download mode instead of user code.
// - Strobe not low at release selects normal mode running user code.
// - Outside the reset sampling window the fetch strobe is driven.
// - Debug mode shares the download entry path exactly.
// - External select picks memory; pulled high it carries emulation access.
// - Core clock comes from a PLL locked at 384 times 32.768 kHz.
// - After reset release registers default and execution starts at vector.
`timescale 1ns/100ps
`include "boot_strap_params.svh"
module boot_mode_strap_and_chip_id #(
  parameter int unsigned LOCK_CYCLES = int'(
    (64'(`PLL_LOCK_TIME_US) * 64'(`CORE_CLK_HZ) + 64'(`US_PER_S) - 64'd1)
    / 64'(`US_PER_S)),
  // Arbitrary family code and revision, no meaning beyond this design
  parameter logic [3:0] FAMILY_CODE = 4'hA,
  parameter logic [3:0] FAMILY_REV  = 4'h1
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  // Special-function register port
  input  wire boot_strap_pkg::sfr_req_s sfr_req,
  output logic [7:0]                    sfr_rdata,
  output logic                          sfr_rdata_valid,
  // Core and emulation controller side
  input  wire logic                     fetch_strobe_n,
  input  wire logic                     emulator_attached,
  input  wire logic                     emulation_tx,
  input  wire logic                     emulation_tx_oe,
  output logic                          emulation_rx,
  // Program fetch strobe pin
  input  wire logic                     program_fetch_strobe_n_in,
  output logic                          program_fetch_strobe_n_out,
  output logic                          program_fetch_strobe_n_oe,
  // External program select pin
  input  wire logic                     external_program_select_n_in,
  output logic                          external_program_select_n_out,
  output logic                          external_program_select_n_oe,
  // Boot status
  output boot_strap_pkg::boot_status_s  status,
  output logic                          exec_start,
  output logic [15:0]                   exec_vector
);
  import boot_strap_pkg::*;

  localparam int unsigned PLL_FREQ_HZ = `XTAL_FREQ_HZ * `PLL_MULT;
  localparam int unsigned CNT_W = $clog2(LOCK_CYCLES + 1);

  generate
    if (LOCK_CYCLES < 2)
    begin : g_bad_lock
      $error("LOCK_CYCLES must be at least 2");
    end
    // The core clock must not run slower than the PLL output it stands for
    if (`CORE_CLK_HZ < PLL_FREQ_HZ)
    begin : g_bad_clock
      $error("core clock below PLL output frequency");
    end
  endgenerate

  logic [1:0]       pin_level;
  logic             strobe_level;
  logic             select_level;
  logic             rst_q;
  logic             release_edge;
  boot_state_e      state;
  logic [CNT_W-1:0] lock_cnt;
  logic             lock_done;
  logic             id_hit;

  pin_strap_sync #(
    .WIDTH (2)
  ) u_sync (
    .core_clk  (core_clk),
    .pin_raw   ({external_program_select_n_in, program_fetch_strobe_n_in}),
    .pin_level (pin_level)
  );

  assign strobe_level = pin_level[0];
  assign select_level = pin_level[1];
  assign emulation_rx = select_level;

  // Only the falling edge of reset opens the sampling instant
  always_ff @(posedge core_clk)
  begin
    rst_q <= rst;
  end

  assign release_edge = rst_q && !rst;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      status.mode            <= BOOT_NORMAL;
      status.external_memory <= 1'b0;
      status.emulation       <= 1'b0;
    end
    else if (release_edge)
    begin
      // Download and debug share this single entry
      status.mode <= (strobe_level == `STRAP_DOWNLOAD_LVL)
                     ? BOOT_DOWNLOAD : BOOT_NORMAL;
      status.external_memory <= (select_level != `EXT_SEL_INTERNAL);
      status.emulation       <= (select_level == `EXT_SEL_INTERNAL)
                                && emulator_attached;
    end
  end

  // Lock wait stands in for PLL settling before code runs
  assign lock_done = (lock_cnt == CNT_W'(LOCK_CYCLES - 1));

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= ST_HOLD;
    end
    else
    begin
      unique case (state)
        ST_HOLD:
        begin
          if (release_edge)
          begin
            state <= ST_LOCK_WAIT;
          end
        end
        ST_LOCK_WAIT:
        begin
          if (lock_done)
          begin
            state <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          state <= ST_RUN;
        end
        default:
        begin
          state <= ST_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || state != ST_LOCK_WAIT)
    begin
      lock_cnt <= '0;
    end
    else if (!lock_done)
    begin
      lock_cnt <= lock_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      status.pll_locked <= 1'b0;
      exec_start        <= 1'b0;
      exec_vector       <= `EXEC_RESET_VECTOR;
    end
    else
    begin
      status.pll_locked <= status.pll_locked
                           || (state == ST_LOCK_WAIT && lock_done);
      exec_start  <= (state == ST_LOCK_WAIT) && lock_done;
      exec_vector <= `EXEC_RESET_VECTOR;
    end
  end

  // Strobe pin stays released through reset and the first lock-wait cycle after the release edge
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      program_fetch_strobe_n_oe  <= 1'b0;
      program_fetch_strobe_n_out <= 1'b1;
    end
    else
    begin
      program_fetch_strobe_n_oe  <= !release_edge;
      // No external fetches while downloading, so the strobe idles high
      program_fetch_strobe_n_out <= (status.mode == BOOT_DOWNLOAD)
                                    ? 1'b1 : fetch_strobe_n;
    end
  end

  // Emulation link may drive the select pin only when it was pulled high
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      external_program_select_n_oe  <= 1'b0;
      external_program_select_n_out <= 1'b1;
    end
    else
    begin
      external_program_select_n_oe  <= status.emulation
                                       && emulation_tx_oe;
      external_program_select_n_out <= emulation_tx;
    end
  end

  assign id_hit = (sfr_req.addr == `FAMILY_ID_ADDR);

  // Writes are decoded nowhere, so the identification cannot change
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sfr_rdata       <= `FAMILY_ID_RESET;
      sfr_rdata_valid <= 1'b0;
    end
    else
    begin
      sfr_rdata_valid <= sfr_req.rd && id_hit;
      if (sfr_req.rd && id_hit)
      begin
        sfr_rdata[`FAMILY_CODE_MSB:`FAMILY_CODE_LSB] <= FAMILY_CODE;
        sfr_rdata[`FAMILY_REV_MSB:`FAMILY_REV_LSB]   <= FAMILY_REV;
      end
    end
  end

  chk_id_readback: assert property (@(posedge core_clk) disable iff (rst)
    sfr_req.rd && id_hit |=> sfr_rdata_valid
      && sfr_rdata == {FAMILY_CODE, FAMILY_REV})
    else $error("identification read returned wrong value");

  chk_id_write_ignored: assert property (@(posedge core_clk)
    disable iff (rst)
    sfr_req.wr && !sfr_req.rd |=> $stable(sfr_rdata))
    else $error("write altered identification register");

  chk_family_nibble: assert property (@(posedge core_clk)
    disable iff (rst) sfr_rdata_valid
    |-> sfr_rdata[`FAMILY_CODE_MSB:`FAMILY_CODE_LSB] == FAMILY_CODE)
    else $error("family code nibble wrong");

  chk_strap_download: assert property (@(posedge core_clk)
    disable iff (rst)
    release_edge && strobe_level == 1'b0 |=> status.mode == BOOT_DOWNLOAD)
    else $error("low strap did not select download mode");

  chk_strap_normal: assert property (@(posedge core_clk)
    disable iff (rst)
    release_edge && strobe_level == 1'b1 |=> status.mode == BOOT_NORMAL)
    else $error("high strap did not select normal mode");

  chk_strap_held: assert property (@(posedge core_clk) disable iff (rst)
    !release_edge |=> $stable(status.mode) && $stable(status.emulation))
    else $error("strap changed after release");

  chk_strobe_driven: assert property (@(posedge core_clk)
    disable iff (rst)
    state != ST_HOLD |=> program_fetch_strobe_n_oe)
    else $error("fetch strobe not driven after sampling");

  chk_strobe_released: assert property (@(posedge core_clk)
    rst |=> !program_fetch_strobe_n_oe)
    else $error("fetch strobe driven during reset");

  chk_exec_after_lock: assert property (@(posedge core_clk)
    disable iff (rst)
    exec_start |-> status.pll_locked && state == ST_RUN
      && $past(lock_done) && exec_vector == `EXEC_RESET_VECTOR)
    else $error("execution started before lock");

  chk_run_locked: assert property (@(posedge core_clk) disable iff (rst)
    state == ST_RUN |-> status.pll_locked)
    else $error("running without PLL lock");

  chk_emu_drive: assert property (@(posedge core_clk) disable iff (rst)
    external_program_select_n_oe |-> status.emulation)
    else $error("select pin driven outside emulation");

  cov_download_boot: cover property (@(posedge core_clk)
    release_edge ##1 status.mode == BOOT_DOWNLOAD);
  cov_normal_run: cover property (@(posedge core_clk)
    status.mode == BOOT_NORMAL && exec_start);
  cov_id_read: cover property (@(posedge core_clk) sfr_rdata_valid);
  cov_emulation: cover property (@(posedge core_clk) status.emulation);

endmodule : boot_mode_strap_and_chip_id

// *** core/boot_strap_params.svh ***
// Constants for the boot strap and family identification block
`ifndef BOOT_STRAP_PARAMS_SVH
`define BOOT_STRAP_PARAMS_SVH

// Special-function address of the family identification register
`define FAMILY_ID_ADDR      8'hC2
// Read answer held before the first read
`define FAMILY_ID_RESET     8'h00
// Field layout of the identification register
`define FAMILY_CODE_MSB     7
`define FAMILY_CODE_LSB     4
`define FAMILY_REV_MSB      3
`define FAMILY_REV_LSB      0
// Strap level on the fetch strobe that selects download mode
`define STRAP_DOWNLOAD_LVL  1'b0
// Level on the external select pin that selects internal memory
`define EXT_SEL_INTERNAL    1'b1
// Execution start address after reset
`define EXEC_RESET_VECTOR   16'h0000
// Clock plan: crystal, multiplier, core clock
`define XTAL_FREQ_HZ        32768
`define PLL_MULT            384
`define CORE_CLK_HZ         25000000
// Lock wait after reset release, in microseconds
`define PLL_LOCK_TIME_US    1000
`define US_PER_S            1000000

`endif

// *** core/boot_strap_pkg.sv ***
// Types shared by the boot strap and family identification block
package boot_strap_pkg;

  typedef enum logic {
    BOOT_NORMAL,
    BOOT_DOWNLOAD
  } boot_mode_e;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_LOCK_WAIT,
    ST_RUN
  } boot_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    boot_mode_e mode;
    logic       external_memory;
    logic       emulation;
    logic       pll_locked;
  } boot_status_s;

endpackage : boot_strap_pkg

// *** core/pin_strap_sync.sv ***
// Three-stage pin synchroniser with agreement filter, one per pin
`timescale 1ns/100ps
module pin_strap_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock
  input  wire logic             core_clk,
  // Raw pins
  input  wire logic [WIDTH-1:0] pin_raw,
  // Filtered levels
  output logic      [WIDTH-1:0] pin_level
);

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("pin_strap_sync needs at least one pin");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
      logic s1;
      logic s2;
      logic s3;
      // Left free-running through reset so the strap is settled at release
      always_ff @(posedge core_clk)
      begin
        s1 <= pin_raw[i];
        s2 <= s1;
        s3 <= s2;
      end
      always_ff @(posedge core_clk)
      begin
        if (s2 == s3)
        begin
          pin_level[i] <= s3;
        end
      end
    end
  endgenerate

endmodule : pin_strap_sync

// *** sim/boot_board_model.sv ***
// Board model: download jumper on the strobe, strap resistor on select
`timescale 1ns/100ps
module boot_board_model (
  // Board straps
  input  wire logic jumper_on,
  input  wire logic select_high,
  // Device drive of both pins
  input  wire logic strobe_out,
  input  wire logic strobe_oe,
  input  wire logic select_out,
  input  wire logic select_oe,
  // Resolved pin levels
  output logic      strobe_pin,
  output logic      select_pin
);
  // Device drive wins; undriven, only the jumper pulls low, otherwise the pin rests high on its pull-up
  assign strobe_pin = strobe_oe ? strobe_out : !jumper_on;
  // Strap resistor level unless the emulator side drives
  assign select_pin = select_oe ? select_out : select_high;
endmodule : boot_board_model

// *** sim/boot_mode_strap_and_chip_id_tb.sv ***
// Testbench for boot strap capture and family identification
`timescale 1ns/100ps
module boot_mode_strap_and_chip_id_tb;
  import boot_strap_pkg::*;
  localparam int unsigned LOCK = 4;
  logic                core_clk = 1'b0;
  logic                rst = 1'b1;
  sfr_req_s            req = '0;
  logic [7:0]          rdata;
  logic                rvalid;
  logic                fetch_n = 1'b1;
  logic                emu_att = 1'b0;
  logic                emu_tx = 1'b1;
  logic                emu_tx_oe = 1'b0;
  logic                emu_rx;
  logic                ps_pin, ps_out, ps_oe;
  logic                sel_pin, sel_out, sel_oe;
  logic                jumper = 1'b0;
  logic                sel_high = 1'b1;
  boot_status_s        status;
  logic                exec_start;
  logic [15:0]         exec_vector;
  int                  n_errors = 0;
  int                  n_compared = 0;
  int                  cycles = 0;

  always #20 core_clk = ~core_clk;

  boot_mode_strap_and_chip_id #(.LOCK_CYCLES(LOCK)) uut (
    .core_clk(core_clk), .rst(rst), .sfr_req(req),
    .sfr_rdata(rdata), .sfr_rdata_valid(rvalid),
    .fetch_strobe_n(fetch_n), .emulator_attached(emu_att),
    .emulation_tx(emu_tx), .emulation_tx_oe(emu_tx_oe),
    .emulation_rx(emu_rx),
    .program_fetch_strobe_n_in(ps_pin),
    .program_fetch_strobe_n_out(ps_out),
    .program_fetch_strobe_n_oe(ps_oe),
    .external_program_select_n_in(sel_pin),
    .external_program_select_n_out(sel_out),
    .external_program_select_n_oe(sel_oe),
    .status(status), .exec_start(exec_start), .exec_vector(exec_vector));

  boot_board_model board (
    .jumper_on(jumper), .select_high(sel_high),
    .strobe_out(ps_out), .strobe_oe(ps_oe),
    .select_out(sel_out), .select_oe(sel_oe),
    .strobe_pin(ps_pin), .select_pin(sel_pin));

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // Bounded so a silent design cannot hang the run
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 2000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  // One read or write strobe; answer looked at in the cycle it stands
  task automatic sfr_access(input logic [7:0] a, input logic wr,
                            input logic valid_exp, input logic [7:0] d_exp);
    @(posedge core_clk);
    req <= '{addr: a, rd: !wr, wr: wr, wdata: 8'h5A};
    @(posedge core_clk);
    req <= '0;
    #1;
    chk("read valid", {15'h0, rvalid}, {15'h0, valid_exp && !wr});
    chk("read data", {8'h00, rdata}, {8'h00, d_exp});
  endtask : sfr_access

  // Reset with given straps, then wait for execution start
  task automatic boot(input logic jmp, input logic selh, input logic att,
                      input logic [3:0] st_exp);
    int n;
    // Straps and reset change only at a rising edge
    @(posedge core_clk);
    jumper <= jmp;
    sel_high <= selh;
    emu_att <= att;
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk("strobe oe in reset", {15'h0, ps_oe}, 16'h0000);
    chk("status in reset", {12'h0, status}, 16'h0000);
    @(posedge core_clk);
    rst <= 1'b0;
    n = 0;
    do
    begin
      @(posedge core_clk);
      // Start pulse stands one cycle, so look after it settles
      #1;
      n++;
    end
    while (exec_start !== 1'b1 && n < LOCK + 8);
    chk("start seen", {15'h0, exec_start}, 16'h0001);
    chk("vector", exec_vector, 16'h0000);
    chk("status", {12'h0, status}, {12'h0, st_exp});
    chk("strobe oe", {15'h0, ps_oe}, 16'h0001);
  endtask : boot

  initial
  begin
    // Normal boot, internal memory, no emulator
    boot(1'b0, 1'b1, 1'b0, 4'b0001);
    sfr_access(8'hC2, 1'b0, 1'b1, 8'hA1);
    sfr_access(8'hC2, 1'b0, 1'b1, 8'hA1);
    sfr_access(8'hC3, 1'b0, 1'b0, 8'hA1);
    sfr_access(8'hC2, 1'b1, 1'b0, 8'hA1);
    sfr_access(8'hC2, 1'b0, 1'b1, 8'hA1);
    @(posedge core_clk);
    fetch_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("strobe follows core", {15'h0, ps_pin}, 16'h0000);
    // Download boot; strap held although the jumper comes off
    boot(1'b1, 1'b1, 1'b0, 4'b1001);
    chk("download strobe high", {15'h0, ps_out}, 16'h0001);
    @(posedge core_clk);
    jumper <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    chk("mode held", {15'h0, status.mode}, 16'h0001);
    // Select pin low: external memory
    boot(1'b0, 1'b0, 1'b0, 4'b0101);
    chk("select oe", {15'h0, sel_oe}, 16'h0000);
    // Select high with emulator: emulation path through the pin
    boot(1'b0, 1'b1, 1'b1, 4'b0011);
    @(posedge core_clk);
    emu_tx <= 1'b0;
    emu_tx_oe <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    chk("emu select oe", {15'h0, sel_oe}, 16'h0001);
    chk("emu rx", {15'h0, emu_rx}, 16'h0000);
    chk("emu select out", {15'h0, sel_out}, 16'h0000);
    chk("status kept", {12'h0, status}, 16'h0003);
    give_verdict();
  end
endmodule : boot_mode_strap_and_chip_id_tb
